// ===== design/scsp_device.sv
`timescale 1ns/100ps
// Summary of operation
// - both ends time bits at shared baud
// - frame is eight data, no parity, one stop
// - idle transmitter holds line high
// - low start bit, then data LSB first
// - stop bit high at least one bit
// - default baud after reset is 9600
// - error output high while error stops motor
// - low reset pin hard-resets, de-energizes motor
// - host waits 10 ms after reset release
// - watchdog times out without periodic commands
// - host resends watchdog kick within a second; scsp_host sends WDOG_KICK_CMD only when given it on tx_data
module scsp_device #(
  parameter int unsigned WDOG_CYCLES = scsp_pkg::WDOG_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  scsp_link_if.dev_mp     link,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_frame_err,
  input  wire logic       wdog_enable,
  input  wire logic       wdog_kick,
  input  wire logic       fault,
  output logic            motor_enable,
  output logic            wdog_timeout
);
  import scsp_pkg::*;

  // pin inputs: three flops, change once 2nd and 3rd agree
  logic [2:0] rx_sync_q, rx_sync_d;
  logic [2:0] rst_sync_q, rst_sync_d;
  logic       rx_line_q, rx_line_d;
  logic       hard_rst_q, hard_rst_d;

  always_comb begin
    rx_sync_d  = {rx_sync_q[1:0], link.host_to_dev};
    rst_sync_d = {rst_sync_q[1:0], link.reset_n};
    rx_line_d  = (rx_sync_q[2] == rx_sync_q[1]) ? rx_sync_q[2] : rx_line_q;
    hard_rst_d = (rst_sync_q[2] == rst_sync_q[1]) ? ~rst_sync_q[2] : hard_rst_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_sync_q  <= 3'h7;
      rst_sync_q <= 3'h7;
      rx_line_q  <= 1'b1;
      hard_rst_q <= 1'b0;
    end else begin
      rx_sync_q  <= rx_sync_d;
      rst_sync_q <= rst_sync_d;
      rx_line_q  <= rx_line_d;
      hard_rst_q <= hard_rst_d;
    end
  end

  // reset pin acts like the core reset
  logic srst;
  assign srst = reset | hard_rst_q;

  // receiver
  scsp_state_type      rx_st_q, rx_st_d;
  logic [CNT_W-1:0]    rx_cnt_q, rx_cnt_d;
  logic [BIT_CNT_W-1:0] rx_bit_q, rx_bit_d;
  logic [7:0]          rx_sh_q, rx_sh_d;
  logic [7:0]          rx_data_q, rx_data_d;
  logic                rx_valid_q, rx_valid_d;
  logic                rx_ferr_q, rx_ferr_d;

  always_comb begin
    rx_st_d    = rx_st_q;
    rx_cnt_d   = rx_cnt_q + 32'h1;
    rx_bit_d   = rx_bit_q;
    rx_sh_d    = rx_sh_q;
    rx_data_d  = rx_data_q;
    rx_valid_d = 1'b0;
    rx_ferr_d  = 1'b0;
    case (rx_st_q)
      SCSP_IDLE: begin
        rx_cnt_d = '0;
        if (!rx_line_q) rx_st_d = SCSP_START;
      end
      SCSP_START: begin
        if (rx_cnt_q == CNT_W'(HALF_CYCLES - 1)) begin
          rx_cnt_d = '0;
          rx_bit_d = '0;
          // glitch shorter than half a bit is dropped
          rx_st_d  = rx_line_q ? SCSP_IDLE : SCSP_DATA;
        end
      end
      SCSP_DATA: begin
        if (rx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
          rx_cnt_d = '0;
          rx_sh_d  = {rx_line_q, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == BIT_CNT_W'(DATA_BITS - 1)) rx_st_d = SCSP_STOP;
        end
      end
      SCSP_STOP: begin
        if (rx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
          rx_st_d = SCSP_IDLE;
          if (rx_line_q) begin
            rx_data_d  = rx_sh_q;
            rx_valid_d = 1'b1;
          end else begin
            rx_ferr_d = 1'b1;
          end
        end
      end
      default: rx_st_d = SCSP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_st_q    <= SCSP_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      rx_data_q  <= '0;
      rx_valid_q <= 1'b0;
      rx_ferr_q  <= 1'b0;
    end else begin
      rx_st_q    <= rx_st_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bit_q   <= rx_bit_d;
      rx_sh_q    <= rx_sh_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      rx_ferr_q  <= rx_ferr_d;
    end
  end

  // transmitter: frame shifted out of a 10-bit register
  logic                 tx_busy_q, tx_busy_d;
  logic [9:0]           tx_sh_q, tx_sh_d;
  logic [CNT_W-1:0]     tx_cnt_q, tx_cnt_d;
  logic [BIT_CNT_W-1:0] tx_bit_q, tx_bit_d;
  logic                 tx_line_q, tx_line_d;

  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_line_d = 1'b1;
    if (!tx_busy_q) begin
      if (tx_valid) begin
        tx_busy_d = 1'b1;
        tx_sh_d   = {1'b1, tx_data, 1'b0};
        tx_cnt_d  = '0;
        tx_bit_d  = '0;
      end
    end else begin
      tx_line_d = tx_sh_q[0];
      if (tx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
        tx_cnt_d = '0;
        tx_sh_d  = {1'b1, tx_sh_q[9:1]};
        tx_bit_d = tx_bit_q + 4'h1;
        // stop bit runs a full period before ready returns
        if (tx_bit_q == BIT_CNT_W'(DATA_BITS + 1)) tx_busy_d = 1'b0;
      end else begin
        tx_cnt_d = tx_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3ff;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_line_q <= 1'b1;
    end else begin
      tx_busy_q <= tx_busy_d;
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_line_q <= tx_line_d;
    end
  end

  // command watchdog and error state
  logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic             wd_to_q, wd_to_d;
  logic             err_q, err_d;
  logic             men_q, men_d;
  logic             kick;

  // kick from the command decoder or the reserved byte on the wire
  assign kick = wdog_kick | (rx_valid_q && rx_data_q == WDOG_KICK_CMD);

  always_comb begin
    wd_cnt_d = kick ? '0 : wd_cnt_q;
    wd_to_d  = wd_to_q;
    if (!wdog_enable) begin
      wd_cnt_d = '0;
      wd_to_d  = 1'b0;
    end else if (!kick) begin
      if (wd_cnt_q == CNT_W'(WDOG_CYCLES - 1)) wd_to_d = 1'b1;
      else wd_cnt_d = wd_cnt_q + 32'h1;
    end
    // a timeout stays latched until the next reset or until wdog_enable goes low
    err_d = wd_to_d | fault;
    men_d = ~err_d;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wd_cnt_q <= '0;
      wd_to_q  <= 1'b0;
      err_q    <= 1'b0;
      men_q    <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      wd_to_q  <= wd_to_d;
      err_q    <= err_d;
      men_q    <= men_d;
    end
  end

  assign link.dev_to_host = tx_line_q;
  assign link.err         = err_q;
  assign tx_ready         = ~tx_busy_q;
  assign rx_data          = rx_data_q;
  assign rx_valid         = rx_valid_q;
  assign rx_frame_err     = rx_ferr_q;
  assign motor_enable     = men_q;
  assign wdog_timeout     = wd_to_q;
endmodule // scsp_device

// ===== design/scsp_pkg.sv
package scsp_pkg;
  // link timing at ref_clk 125 MHz
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned BAUD_DEFAULT   = 9600;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned HALF_CYCLES    = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS      = 8;
  // host waits this long after releasing the device reset
  localparam int unsigned RESET_WAIT_MS  = 10;
  localparam int unsigned RESET_WAIT_CYC = (CLK_HZ / 1000) * RESET_WAIT_MS;
  // command watchdog: about one second of silence
  localparam int unsigned WDOG_MS        = 1000;
  localparam int unsigned WDOG_CYC       = (CLK_HZ / 1000) * WDOG_MS;
  localparam logic        WDOG_EN_RESET  = 1'b1;
  localparam logic [7:0]  WDOG_KICK_CMD  = 8'h8c;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned BIT_CNT_W      = 4;

  typedef enum logic [1:0] {
    SCSP_IDLE  = 2'b00,
    SCSP_START = 2'b01,
    SCSP_DATA  = 2'b10,
    SCSP_STOP  = 2'b11
  } scsp_state_type;
endpackage

// ===== design/scsp_link_if.sv
`timescale 1ns/100ps
// two one-way lines, each idling high
interface scsp_link_if;
  logic host_to_dev;
  logic dev_to_host;
  logic reset_n;
  logic err;
  modport dev_mp  (input host_to_dev, input reset_n, output dev_to_host, output err);
  modport host_mp (output host_to_dev, output reset_n, input dev_to_host, input err);
endinterface

// ===== design/scsp_host.sv
`timescale 1ns/100ps
// host end: transmitter, receiver, device reset driver
module scsp_host #(
  parameter int unsigned RESET_WAIT = scsp_pkg::RESET_WAIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  scsp_link_if.host_mp    link,
  input  wire logic       dev_reset_req,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            dev_err
);
  import scsp_pkg::*;

  // synchronisers for device outputs
  logic [2:0] rx_sync_q, rx_sync_d;
  logic [2:0] er_sync_q, er_sync_d;
  logic       rx_line_q, rx_line_d;
  logic       err_q, err_d;

  always_comb begin
    rx_sync_d = {rx_sync_q[1:0], link.dev_to_host};
    er_sync_d = {er_sync_q[1:0], link.err};
    rx_line_d = (rx_sync_q[2] == rx_sync_q[1]) ? rx_sync_q[2] : rx_line_q;
    err_d     = (er_sync_q[2] == er_sync_q[1]) ? er_sync_q[2] : err_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_sync_q <= 3'h7;
      er_sync_q <= 3'h0;
      rx_line_q <= 1'b1;
      err_q     <= 1'b0;
    end else begin
      rx_sync_q <= rx_sync_d;
      er_sync_q <= er_sync_d;
      rx_line_q <= rx_line_d;
      err_q     <= err_d;
    end
  end

  // device reset pulse and post-release hold-off
  logic             rst_n_q, rst_n_d;
  logic [CNT_W-1:0] wait_q, wait_d;

  always_comb begin
    rst_n_d = ~dev_reset_req;
    wait_d  = wait_q;
    if (dev_reset_req) wait_d = CNT_W'(RESET_WAIT);
    else if (wait_q != '0) wait_d = wait_q - 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rst_n_q <= 1'b1;
      wait_q  <= '0;
    end else begin
      rst_n_q <= rst_n_d;
      wait_q  <= wait_d;
    end
  end

  // transmitter
  logic                 tx_busy_q, tx_busy_d;
  logic [9:0]           tx_sh_q, tx_sh_d;
  logic [CNT_W-1:0]     tx_cnt_q, tx_cnt_d;
  logic [BIT_CNT_W-1:0] tx_bit_q, tx_bit_d;
  logic                 tx_line_q, tx_line_d;
  logic                 rdy_q, rdy_d;

  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_line_d = 1'b1;
    if (!tx_busy_q) begin
      if (tx_valid && rdy_q) begin
        tx_busy_d = 1'b1;
        tx_sh_d   = {1'b1, tx_data, 1'b0};
        tx_cnt_d  = '0;
        tx_bit_d  = '0;
      end
    end else begin
      tx_line_d = tx_sh_q[0];
      if (tx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
        tx_cnt_d = '0;
        tx_sh_d  = {1'b1, tx_sh_q[9:1]};
        tx_bit_d = tx_bit_q + 4'h1;
        if (tx_bit_q == BIT_CNT_W'(DATA_BITS + 1)) tx_busy_d = 1'b0;
      end else begin
        tx_cnt_d = tx_cnt_q + 32'h1;
      end
    end
    // no sends while device is held or settling
    rdy_d = ~tx_busy_d & rst_n_d & (wait_d == '0);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3ff;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_line_q <= 1'b1;
      rdy_q     <= 1'b0;
    end else begin
      tx_busy_q <= tx_busy_d;
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_line_q <= tx_line_d;
      rdy_q     <= rdy_d;
    end
  end

  // receiver, mid-bit sampling
  scsp_state_type       rx_st_q, rx_st_d;
  logic [CNT_W-1:0]     rx_cnt_q, rx_cnt_d;
  logic [BIT_CNT_W-1:0] rx_bit_q, rx_bit_d;
  logic [7:0]           rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
  logic                 rx_valid_q, rx_valid_d;

  always_comb begin
    rx_st_d    = rx_st_q;
    rx_cnt_d   = rx_cnt_q + 32'h1;
    rx_bit_d   = rx_bit_q;
    rx_sh_d    = rx_sh_q;
    rx_data_d  = rx_data_q;
    rx_valid_d = 1'b0;
    case (rx_st_q)
      SCSP_IDLE: begin
        rx_cnt_d = '0;
        if (!rx_line_q) rx_st_d = SCSP_START;
      end
      SCSP_START: begin
        if (rx_cnt_q == CNT_W'(HALF_CYCLES - 1)) begin
          rx_cnt_d = '0;
          rx_bit_d = '0;
          rx_st_d  = rx_line_q ? SCSP_IDLE : SCSP_DATA;
        end
      end
      SCSP_DATA: begin
        if (rx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
          rx_cnt_d = '0;
          rx_sh_d  = {rx_line_q, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == BIT_CNT_W'(DATA_BITS - 1)) rx_st_d = SCSP_STOP;
        end
      end
      SCSP_STOP: begin
        if (rx_cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
          rx_st_d = SCSP_IDLE;
          if (rx_line_q) begin
            rx_data_d  = rx_sh_q;
            rx_valid_d = 1'b1;
          end
        end
      end
      default: rx_st_d = SCSP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_st_q    <= SCSP_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      rx_data_q  <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_st_q    <= rx_st_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bit_q   <= rx_bit_d;
      rx_sh_q    <= rx_sh_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  assign link.host_to_dev = tx_line_q;
  assign link.reset_n     = rst_n_q;
  assign tx_ready         = rdy_q;
  assign rx_data          = rx_data_q;
  assign rx_valid         = rx_valid_q;
  assign dev_err          = err_q;
endmodule // scsp_host

// ===== testbench/scsp_assertions.sv
`timescale 1ns/100ps
// link-side checks, watching only the interface wires
module scsp_assertions
  import scsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic reset_n,
  input wire logic err
);
  int unsigned lo_q [2];
  int unsigned hi_q [2];
  logic [1:0]  line;

  assign line = {dev_to_host, host_to_dev};

  // run lengths of low and high; high starts full so the first start bit passes
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (reset) begin
        lo_q[i] <= 0;
        hi_q[i] <= BIT_CYCLES;
      end else begin
        lo_q[i] <= line[i] ? 0 : lo_q[i] + 1;
        hi_q[i] <= !line[i] ? 0 : (hi_q[i] < BIT_CYCLES ? hi_q[i] + 1 : hi_q[i]);
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence dev_held;
    !reset_n [*8];
  endsequence

  sequence host_start;
    $fell(host_to_dev) ##1 !host_to_dev [*7];
  endsequence

  idle_after_reset_a: assert property ($fell(reset) |-> host_to_dev && dev_to_host)
    else $error("line not idle high after reset");
  h2d_bit_grid_a: assert property ($rose(host_to_dev) |->
    (lo_q[0] % BIT_CYCLES) < 3 || (lo_q[0] % BIT_CYCLES) > BIT_CYCLES - 3)
    else $error("host low run off the bit grid");
  d2h_bit_grid_a: assert property ($rose(dev_to_host) |->
    (lo_q[1] % BIT_CYCLES) < 3 || (lo_q[1] % BIT_CYCLES) > BIT_CYCLES - 3)
    else $error("device low run off the bit grid");
  h2d_stop_len_a: assert property ($fell(host_to_dev) |-> hi_q[0] >= BIT_CYCLES - 2)
    else $error("host stop bit too short");
  d2h_stop_len_a: assert property ($fell(dev_to_host) |-> hi_q[1] >= BIT_CYCLES - 2)
    else $error("device stop bit too short");
  start_bit_hold_a: assert property (host_start |-> ##1 !host_to_dev)
    else $error("host start bit glitched");
  frame_len_a: assert property (lo_q[0] <= 9 * BIT_CYCLES + 3 && lo_q[1] <= 9 * BIT_CYCLES + 3)
    else $error("line low longer than a frame");
  held_line_high_a: assert property (dev_held |-> dev_to_host)
    else $error("device line active in hard reset");
  held_err_low_a: assert property (dev_held |-> !err)
    else $error("error output set in hard reset");
endmodule // scsp_assertions

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import scsp_pkg::*;
  localparam int unsigned B = BIT_CYCLES;
  logic       ref_clk, reset, bad_line;
  logic [7:0] h_tx_data, d_tx_data, h_rx_data, d_rx_data, h_got, d_got;
  logic       h_tx_valid, h_tx_ready, h_rx_valid, h_err, h_rst_req;
  logic       d_tx_valid, d_tx_ready, d_rx_valid, d_ferr, wdog_en, kick, fault;
  logic       motor_en, wdog_to, x_rx_valid, x_ferr;
  int         error_cnt, n_compared, h_n, d_n, x_n, x_fe, cyc;

  scsp_link_if link ();
  scsp_link_if link2 ();
  assign link2.host_to_dev = bad_line;
  assign link2.reset_n     = 1'b1;

  scsp_host #(.RESET_WAIT(100)) scsp_host_inst (.ref_clk(ref_clk), .reset(reset),
    .link(link), .dev_reset_req(h_rst_req), .tx_data(h_tx_data), .tx_valid(h_tx_valid),
    .tx_ready(h_tx_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid), .dev_err(h_err));
  scsp_device #(.WDOG_CYCLES(2000)) scsp_device_inst (.ref_clk(ref_clk), .reset(reset),
    .link(link), .tx_data(d_tx_data), .tx_valid(d_tx_valid), .tx_ready(d_tx_ready),
    .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_frame_err(d_ferr),
    .wdog_enable(wdog_en), .wdog_kick(kick), .fault(fault), .motor_enable(motor_en),
    .wdog_timeout(wdog_to));
  // second device fed by a deliberately broken frame
  scsp_device #(.WDOG_CYCLES(2000)) scsp_device_inst2 (.ref_clk(ref_clk), .reset(reset),
    .link(link2), .tx_data(8'h00), .tx_valid(1'b0), .tx_ready(), .rx_data(),
    .rx_valid(x_rx_valid), .rx_frame_err(x_ferr), .wdog_enable(wdog_en), .wdog_kick(kick),
    .fault(fault), .motor_enable(), .wdog_timeout());
  scsp_assertions scsp_assertions_inst (.ref_clk(ref_clk), .reset(reset),
    .host_to_dev(link.host_to_dev), .dev_to_host(link.dev_to_host),
    .reset_n(link.reset_n), .err(link.err));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // received-byte capture; rx_valid stands one cycle only
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (h_rx_valid === 1'b1) begin h_got <= h_rx_data; h_n <= h_n + 1; end
    if (d_rx_valid === 1'b1) begin d_got <= d_rx_data; d_n <= d_n + 1; end
    if (x_rx_valid === 1'b1) x_n <= x_n + 1;
    if (x_ferr === 1'b1) x_fe <= x_fe + 1;
    if (cyc == 500000) begin error_cnt++; end_sim(); end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bit1(input logic got, input logic exp);
    check({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  function automatic logic ln(input bit sel);
    return sel ? link.host_to_dev : link.dev_to_host;
  endfunction

  // sel 1 = host transmitter, 0 = device transmitter
  task automatic send(input bit sel, input logic [7:0] d);
    for (int i = 0; i < 12 * B && (sel ? h_tx_ready : d_tx_ready) !== 1'b1; i++) wait_cyc(1);
    bit1(sel ? h_tx_ready : d_tx_ready, 1'b1);
    if (sel) begin h_tx_data = d; h_tx_valid = 1'b1; end
    else begin d_tx_data = d; d_tx_valid = 1'b1; end
    wait_cyc(1);
    if (sel) h_tx_valid = 1'b0;
    else d_tx_valid = 1'b0;
  endtask

  // mid-bit samples of one frame on the wire
  task automatic watch(input bit sel, input logic [7:0] d);
    for (int i = 0; i < 12 * B && ln(sel) === 1'b1; i++) wait_cyc(1);
    wait_cyc(HALF_CYCLES);
    bit1(ln(sel), 1'b0);
    for (int k = 0; k < 8; k++) begin
      wait_cyc(B);
      bit1(ln(sel), d[k]);
    end
    wait_cyc(B);
    bit1(ln(sel), 1'b1);
  endtask

  // good start and data, stop bit held low
  task automatic bad_frame(input logic [7:0] d);
    bad_line = 1'b0;
    wait_cyc(B);
    for (int k = 0; k < 8; k++) begin bad_line = d[k]; wait_cyc(B); end
    bad_line = 1'b0;
    wait_cyc(B);
    bad_line = 1'b1;
  endtask

  initial begin
    {h_tx_data, d_tx_data, h_tx_valid, d_tx_valid, h_rst_req} = '0;
    {wdog_en, kick, fault, error_cnt, n_compared, h_n, d_n, x_n, x_fe, cyc} = '0;
    bad_line = 1'b1;
    reset    = 1'b1;
    wait_cyc(16);
    reset = 1'b0;
    wait_cyc(4);
    check({link.host_to_dev, link.dev_to_host}, 8'h03);
    check({motor_en, h_err}, 8'h02);
    // kicks inside the limit keep the motor running
    wdog_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_cyc(1500);
      kick = 1'b1;
      wait_cyc(1);
      kick = 1'b0;
    end
    check({wdog_to, motor_en}, 8'h01);
    wait_cyc(2100);
    check({wdog_to, motor_en, h_err}, 8'h05);
    wdog_en = 1'b0;
    wait_cyc(8);
    check({wdog_to, h_err}, 8'h00);
    fault = 1'b1;
    wait_cyc(8);
    check({motor_en, h_err}, 8'h01);
    fault = 1'b0;
    wait_cyc(8);
    check({motor_en, h_err}, 8'h02);
    // hard reset through the pin, then the host hold-off
    h_rst_req = 1'b1;
    wait_cyc(12);
    check({link.reset_n, motor_en}, 8'h00);
    h_rst_req = 1'b0;
    wait_cyc(50);
    bit1(h_tx_ready, 1'b0);
    wait_cyc(60);
    bit1(h_tx_ready, 1'b1);
    fork
      send(1, WDOG_KICK_CMD);
      send(0, 8'ha5);
      watch(1, WDOG_KICK_CMD);
      watch(0, 8'ha5);
      bad_frame(8'h3c);
    join
    wait_cyc(B);
    check(d_got, WDOG_KICK_CMD);
    check(h_got, 8'ha5);
    check(8'(x_fe), 8'h01);
    check(8'(x_n), 8'h00);
    // back to back, extreme patterns
    fork
      begin send(1, 8'h00); send(1, 8'hff); end
      begin watch(1, 8'h00); watch(1, 8'hff); end
    join
    wait_cyc(B);
    check(d_got, 8'hff);
    check(8'(d_n), 8'h03);
    end_sim();
  end
endmodule // tb_top
